// *** inc/sesrq_pkg.sv ***
package sesrq_pkg;

  // -----------------------------------------------------------------
  // register widths
  // -----------------------------------------------------------------
  localparam int SRQ_MASK_W = 8;
  localparam int EVT_W = 16;

  // -----------------------------------------------------------------
  // event latch bit positions
  // -----------------------------------------------------------------
  localparam int EV_OP_COMPLETE = 0;
  localparam int EV_QUERY_FAULT = 2;
  localparam int EV_DEVICE_FAULT = 3;
  localparam int EV_EXEC_FAULT = 4;
  localparam int EV_CMD_FAULT = 5;
  localparam int EV_POWER_UP = 7;

  // mask of implemented event bits; all others read as zero
  localparam logic [15:0] EV_USED_MASK = 16'h00bd;

  // -----------------------------------------------------------------
  // status byte bit positions
  // -----------------------------------------------------------------
  localparam int SB_QUES = 3;
  localparam int SB_EVENT_SUMMARY = 5;
  localparam int SB_MASTER_SUMMARY = 6;
  localparam int SB_OPER = 7;

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [7:0] SRQ_MASK_RST = 8'h00;
  localparam logic [15:0] EVT_MASK_RST = 16'h0000;
  localparam logic [15:0] EVT_LATCH_RST = 16'h0000;

  // -----------------------------------------------------------------
  // common command codes on the command port
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    SESRQ_CMD_NONE,
    SESRQ_CMD_SET_SRQ_MASK,
    SESRQ_CMD_QRY_SRQ_MASK,
    SESRQ_CMD_SET_EVT_MASK,
    SESRQ_CMD_QRY_EVT_MASK,
    SESRQ_CMD_QRY_EVT_LATCH,
    SESRQ_CMD_CLEAR_STATUS,
    SESRQ_CMD_OP_COMPLETE
  } sesrq_cmd_t;

  // completion tracker states
  typedef enum logic [1:0] {
    SESRQ_OPC_IDLE,
    SESRQ_OPC_ARMED
  } sesrq_opc_state_t;

endpackage : sesrq_pkg

// *** core/sesrq_opc_tracker.sv ***
`timescale 1ns/10ps

// waits for all overlapped work to finish after an arm request
module sesrq_opc_tracker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control
  input wire logic arm,
  input wire logic opsPending,
  // result
  output logic donePulse
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    sesrq_pkg::sesrq_opc_state_t st;
    logic done;
  } sesrq_opc_reg_t;

  sesrq_opc_reg_t r_q;
  sesrq_opc_reg_t r_d;

  // arm waits while anything is pending; a re-arm just restarts the wait
  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    unique case (r_q.st)
      sesrq_pkg::SESRQ_OPC_IDLE: begin
        if (arm) begin
          r_d.st = sesrq_pkg::SESRQ_OPC_ARMED;
        end
      end
      sesrq_pkg::SESRQ_OPC_ARMED: begin
        if (!opsPending && !arm) begin
          r_d.done = 1'b1;
          r_d.st = sesrq_pkg::SESRQ_OPC_IDLE;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r_q <= '{st: sesrq_pkg::SESRQ_OPC_IDLE, done: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  assign donePulse = r_q.done;

endmodule : sesrq_opc_tracker

// *** core/sesrq_status_core.sv ***
`timescale 1ns/10ps

module sesrq_status_core #(
  parameter int EVT_WIDTH = 16,
  parameter int SRQ_WIDTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // common command port
  input wire logic cmdValid,
  input wire logic [2:0] cmdCode,
  input wire logic [15:0] cmdArg,
  // overlapped operation status
  input wire logic opsPending,
  // event sources, rising edges are latched
  input wire logic queryEmptyRead,
  input wire logic queryDataLost,
  input wire logic queryInterrupted,
  input wire logic deviceFault,
  input wire logic execFault,
  input wire logic commandFault,
  // other status byte sources
  input wire logic questionableSummary,
  input wire logic operationSummary,
  input wire logic errorAvailable,
  input wire logic messageAvailable,
  // query answer
  output logic rspValid,
  output logic [15:0] rspData,
  // status byte and request line
  output logic [7:0] statusByte,
  output logic serviceRequest
);

  // -----------------------------------------------------------------
  // decoding helpers
  // -----------------------------------------------------------------
  // rising edge of a level compared with its previous sample
  function automatic logic risen(input logic now, input logic was);
    risen = now & ~was;
  endfunction : risen

  // does a command code match
  function automatic logic isCmd(input logic v, input logic [2:0] c, input sesrq_pkg::sesrq_cmd_t k);
    isCmd = v & (c == k);
  endfunction : isCmd

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [SRQ_WIDTH-1:0] srqMask;
    logic [EVT_WIDTH-1:0] evtMask;
    logic [EVT_WIDTH-1:0] evtLatch;
    logic [5:0] srcPrev;
    logic powerUpPending;
    logic rspValid;
    logic [15:0] rspData;
    logic [7:0] statusByte;
    logic serviceRequest;
  } sesrq_core_reg_t;

  sesrq_core_reg_t r_q;
  sesrq_core_reg_t r_d;

  logic opDone;
  logic [5:0] srcNow;
  logic [EVT_WIDTH-1:0] evtSet;
  logic [7:0] sbNext;
  logic summaryBit;
  logic srqAny;

  // -----------------------------------------------------------------
  // completion tracking
  // -----------------------------------------------------------------
  sesrq_opc_tracker u_opc (
    .sys_clk(sys_clk),
    .rst(rst),
    .arm(isCmd(cmdValid, cmdCode, sesrq_pkg::SESRQ_CMD_OP_COMPLETE)),
    .opsPending(opsPending),
    .donePulse(opDone)
  );

  // -----------------------------------------------------------------
  // event collection
  // -----------------------------------------------------------------
  // the three query faults share one bit, so merge after edge detection of each
  assign srcNow = {commandFault, execFault, deviceFault, queryInterrupted, queryDataLost, queryEmptyRead};

  // set terms per latch bit; only edges matter, holding a fault high sets once
  always_comb begin
    evtSet = '0;
    evtSet[sesrq_pkg::EV_OP_COMPLETE] = opDone;
    evtSet[sesrq_pkg::EV_QUERY_FAULT] = risen(srcNow[0], r_q.srcPrev[0])
      | risen(srcNow[1], r_q.srcPrev[1])
      | risen(srcNow[2], r_q.srcPrev[2]);
    evtSet[sesrq_pkg::EV_DEVICE_FAULT] = risen(srcNow[3], r_q.srcPrev[3]);
    evtSet[sesrq_pkg::EV_EXEC_FAULT] = risen(srcNow[4], r_q.srcPrev[4]);
    evtSet[sesrq_pkg::EV_CMD_FAULT] = risen(srcNow[5], r_q.srcPrev[5]);
    evtSet[sesrq_pkg::EV_POWER_UP] = r_q.powerUpPending;
    evtSet = evtSet & EVT_WIDTH'(sesrq_pkg::EV_USED_MASK);
  end

  // -----------------------------------------------------------------
  // status byte and service request
  // -----------------------------------------------------------------
  // summary looks at the next latch so it tracks the stored contents
  always_comb begin
    summaryBit = |(r_d.evtLatch & r_q.evtMask);
    sbNext = 8'h00;
    sbNext[2] = errorAvailable;
    sbNext[4] = messageAvailable;
    sbNext[sesrq_pkg::SB_QUES] = questionableSummary;
    sbNext[sesrq_pkg::SB_OPER] = operationSummary;
    sbNext[sesrq_pkg::SB_EVENT_SUMMARY] = summaryBit;
    // bit 6 itself is excluded so the request cannot hold itself up
    srqAny = |(sbNext & r_d.srqMask[7:0] & ~(8'h01 << sesrq_pkg::SB_MASTER_SUMMARY));
    sbNext[sesrq_pkg::SB_MASTER_SUMMARY] = srqAny;
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.srcPrev = srcNow;
    r_d.powerUpPending = 1'b0;
    r_d.rspValid = 1'b0;
    // clears happen first so a same-cycle event still lands
    if (isCmd(cmdValid, cmdCode, sesrq_pkg::SESRQ_CMD_CLEAR_STATUS)) begin
      r_d.evtLatch = '0;
    end
    if (isCmd(cmdValid, cmdCode, sesrq_pkg::SESRQ_CMD_QRY_EVT_LATCH)) begin
      r_d.rspValid = 1'b1;
      r_d.rspData = 16'(r_q.evtLatch);
      r_d.evtLatch = '0;
    end
    r_d.evtLatch = r_d.evtLatch | evtSet;
    if (isCmd(cmdValid, cmdCode, sesrq_pkg::SESRQ_CMD_SET_SRQ_MASK)) begin
      r_d.srqMask = cmdArg[SRQ_WIDTH-1:0];
    end
    if (isCmd(cmdValid, cmdCode, sesrq_pkg::SESRQ_CMD_SET_EVT_MASK)) begin
      r_d.evtMask = cmdArg[EVT_WIDTH-1:0];
    end
    if (isCmd(cmdValid, cmdCode, sesrq_pkg::SESRQ_CMD_QRY_SRQ_MASK)) begin
      r_d.rspValid = 1'b1;
      r_d.rspData = 16'(r_q.srqMask);
    end
    if (isCmd(cmdValid, cmdCode, sesrq_pkg::SESRQ_CMD_QRY_EVT_MASK)) begin
      r_d.rspValid = 1'b1;
      r_d.rspData = 16'(r_q.evtMask);
    end
    r_d.statusByte = sbNext;
    r_d.serviceRequest = srqAny;
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  // reset is the power-on event, so it arms the power-up flag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r_q.srqMask <= SRQ_WIDTH'(sesrq_pkg::SRQ_MASK_RST);
      r_q.evtMask <= EVT_WIDTH'(sesrq_pkg::EVT_MASK_RST);
      r_q.evtLatch <= EVT_WIDTH'(sesrq_pkg::EVT_LATCH_RST);
      r_q.srcPrev <= 6'h3f; // faults already high at reset do not count
      r_q.powerUpPending <= 1'b1;
      r_q.rspValid <= 1'b0;
      r_q.rspData <= 16'h0000;
      r_q.statusByte <= 8'h00;
      r_q.serviceRequest <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign rspValid = r_q.rspValid;
  assign rspData = r_q.rspData;
  assign statusByte = r_q.statusByte;
  assign serviceRequest = r_q.serviceRequest;

endmodule : sesrq_status_core

// *** test/sesrq_status_monitor.sv ***
`timescale 1ns/10ps

// ------------------------------
// status core port checker
// ------------------------------
module sesrq_status_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // command port and answer
  input wire logic cmdValid,
  input wire logic [2:0] cmdCode,
  input wire logic [15:0] cmdArg,
  input wire logic rspValid,
  input wire logic [15:0] rspData,
  // sources and status
  input wire logic deviceFault,
  input wire logic commandFault,
  input wire logic questionableSummary,
  input wire logic operationSummary,
  input wire logic [7:0] statusByte,
  input wire logic serviceRequest
);
  localparam logic [2:0] SS = sesrq_pkg::SESRQ_CMD_SET_SRQ_MASK;
  localparam logic [2:0] QS = sesrq_pkg::SESRQ_CMD_QRY_SRQ_MASK;
  localparam logic [2:0] SE = sesrq_pkg::SESRQ_CMD_SET_EVT_MASK;
  localparam logic [2:0] QE = sesrq_pkg::SESRQ_CMD_QRY_EVT_MASK;
  localparam logic [2:0] QL = sesrq_pkg::SESRQ_CMD_QRY_EVT_LATCH;
  localparam logic [2:0] CL = sesrq_pkg::SESRQ_CMD_CLEAR_STATUS;
  logic [7:0] srqMask_q;
  logic [7:0] srqMask2_q;
  logic [15:0] evtMask_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // shadow masks rebuilt from the command port, the checker has no view inside
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      srqMask_q <= sesrq_pkg::SRQ_MASK_RST;
      evtMask_q <= sesrq_pkg::EVT_MASK_RST;
    end else if (cmdValid && cmdCode == SS) begin
      srqMask_q <= cmdArg[7:0];
    end else if (cmdValid && cmdCode == SE) begin
      evtMask_q <= cmdArg;
    end
  end
  // one cycle of mask history, so a fresh write does not race the request
  always_ff @(posedge sys_clk) begin
    srqMask2_q <= srqMask_q;
  end
  property p_rsp; cmdValid && (cmdCode == QS || cmdCode == QE || cmdCode == QL) |=> rspValid; endproperty
  a_rsp: assert property (p_rsp) else $error("query without answer");
  property p_cls; cmdValid && cmdCode == CL |=> !rspValid; endproperty
  a_cls: assert property (p_cls) else $error("clear gave an answer");
  property p_srd; cmdValid && cmdCode == QS |=> rspData == {8'h00, srqMask_q}; endproperty
  a_srd: assert property (p_srd) else $error("request mask readback wrong");
  property p_erd; cmdValid && cmdCode == QE |=> rspData == evtMask_q; endproperty
  a_erd: assert property (p_erd) else $error("event mask readback wrong");
  property p_unused; cmdValid && cmdCode == QL |=> (rspData & ~sesrq_pkg::EV_USED_MASK) == 16'h0000; endproperty
  a_unused: assert property (p_unused) else $error("unused latch bit set");
  property p_ques; !$past(rst) |-> statusByte[3] == $past(questionableSummary); endproperty
  a_ques: assert property (p_ques) else $error("status bit 3 wrong");
  property p_oper; !$past(rst) |-> statusByte[7] == $past(operationSummary); endproperty
  a_oper: assert property (p_oper) else $error("status bit 7 wrong");
  property p_mss; serviceRequest == statusByte[6]; endproperty
  a_mss: assert property (p_mss) else $error("request and bit 6 differ");
  property p_srq; $stable(statusByte) && srqMask_q == srqMask2_q |-> serviceRequest == |(statusByte & srqMask_q & 8'hbf);
  endproperty
  a_srq: assert property (p_srq) else $error("request not masked or");
  sequence s_evt; (($rose(deviceFault) && evtMask_q[3]) || ($rose(commandFault) && evtMask_q[5])) && !cmdValid;
  endsequence
  property p_esb; s_evt ##1 !cmdValid |-> ##[0:1] statusByte[5]; endproperty
  a_esb: assert property (p_esb) else $error("event summary missing");
  c_query: cover property (cmdValid && cmdCode == QL ##1 rspValid);
  c_srq: cover property ($rose(serviceRequest));
  c_esb: cover property ($fell(statusByte[5]));
endmodule : sesrq_status_monitor

bind sesrq_status_core sesrq_status_monitor i_sesrq_status_monitor (.sys_clk, .rst, .cmdValid, .cmdCode, .cmdArg,
  .rspValid, .rspData, .deviceFault, .commandFault, .questionableSummary, .operationSummary, .statusByte, .serviceRequest);

// *** test/sesrq_ctrl_model.sv ***
`timescale 1ns/10ps

// ------------------------------
// remote controller model
// ------------------------------
module sesrq_ctrl_model (
  // clock
  input wire logic sys_clk,
  // command port
  output logic cmdValid,
  output logic [2:0] cmdCode,
  output logic [15:0] cmdArg,
  // answer
  input wire logic rspValid,
  input wire logic [15:0] rspData
);
  initial begin
    cmdValid = 1'b0;
    cmdCode = 3'h0;
    cmdArg = 16'ha5c3;
  end
  // one strobe per command; idle lines are inverted so stale values never help
  task automatic send(input sesrq_pkg::sesrq_cmd_t code, input logic [15:0] arg);
    @(posedge sys_clk);
    cmdValid <= 1'b1;
    cmdCode <= code;
    cmdArg <= arg;
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    cmdCode <= ~code;
    cmdArg <= ~arg;
  endtask : send
  // answer is taken at the edge that shows it, within three cycles
  task automatic query(input sesrq_pkg::sesrq_cmd_t code, output logic [15:0] data, output bit ok);
    ok = 1'b0;
    data = 16'h0000;
    send(code, 16'h5a5a);
    for (int i = 0; i < 3 && !ok; i++) begin
      @(posedge sys_clk);
      ok = rspValid;
      data = rspData;
    end
  endtask : query
endmodule : sesrq_ctrl_model

// *** test/sesrq_status_core_test.sv ***
`timescale 1ns/10ps

// ------------------------------
// status core bench
// ------------------------------
module sesrq_status_core_test;
  localparam sesrq_pkg::sesrq_cmd_t SETS = sesrq_pkg::SESRQ_CMD_SET_SRQ_MASK;
  localparam sesrq_pkg::sesrq_cmd_t QRYS = sesrq_pkg::SESRQ_CMD_QRY_SRQ_MASK;
  localparam sesrq_pkg::sesrq_cmd_t SETE = sesrq_pkg::SESRQ_CMD_SET_EVT_MASK;
  localparam sesrq_pkg::sesrq_cmd_t QRYE = sesrq_pkg::SESRQ_CMD_QRY_EVT_MASK;
  localparam sesrq_pkg::sesrq_cmd_t QRYL = sesrq_pkg::SESRQ_CMD_QRY_EVT_LATCH;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic opsPending = 1'b0;
  logic [5:0] src = 6'h00;
  logic [3:0] sb = 4'h0;
  logic cmdValid;
  logic [2:0] cmdCode;
  logic [15:0] cmdArg;
  logic rspValid;
  logic [15:0] rspData;
  logic [7:0] statusByte;
  logic serviceRequest;
  int errorCnt = 0;
  int comparisons = 0;
  sesrq_status_core i_sesrq_status_core (.sys_clk, .rst, .cmdValid, .cmdCode, .cmdArg, .opsPending,
    .queryEmptyRead(src[0]), .queryDataLost(src[1]), .queryInterrupted(src[2]), .deviceFault(src[3]),
    .execFault(src[4]), .commandFault(src[5]), .questionableSummary(sb[0]), .operationSummary(sb[1]),
    .errorAvailable(sb[2]), .messageAvailable(sb[3]), .rspValid, .rspData, .statusByte, .serviceRequest);
  sesrq_ctrl_model i_sesrq_ctrl_model (.sys_clk, .cmdValid, .cmdCode, .cmdArg, .rspValid, .rspData);
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errorCnt++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic put(input sesrq_pkg::sesrq_cmd_t code, input logic [15:0] arg);
    i_sesrq_ctrl_model.send(code, arg);
  endtask : put
  // a missing answer ends the run rather than hanging it
  task automatic ask(input sesrq_pkg::sesrq_cmd_t code, output logic [15:0] d);
    bit ok;
    i_sesrq_ctrl_model.query(code, d, ok);
    if (!ok) begin
      errorCnt++;
      conclude();
    end
  endtask : ask
  task automatic settle(input logic [15:0] exp);
    repeat (3) @(posedge sys_clk);
    check({serviceRequest, statusByte}, exp);
  endtask : settle
  task automatic t_reset_regs();
    logic [15:0] d;
    ask(QRYS, d);
    check(d, 16'h0000);
    ask(QRYE, d);
    check(d, 16'h0000);
    ask(QRYL, d);
    check(d, 16'h0080);
    ask(QRYL, d);
    check(d, 16'h0000);
    put(SETS, 16'hff88);
    ask(QRYS, d);
    check(d, 16'h0088);
    put(SETE, 16'hffff);
    ask(QRYE, d);
    check(d, 16'hffff);
  endtask : t_reset_regs
  // each source in turn, read back and cleared by the latch query
  task automatic t_events();
    logic [15:0] d;
    logic [15:0] bits [6] = '{16'h0004, 16'h0004, 16'h0004, 16'h0008, 16'h0010, 16'h0020};
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      src[i] <= 1'b1;
      repeat (3) @(posedge sys_clk);
      check(statusByte[5], 1'b1);
      ask(QRYL, d);
      src[i] <= 1'b0;
      check(d, bits[i]);
      repeat (2) @(posedge sys_clk);
      check(statusByte[5], 1'b0);
    end
  endtask : t_events
  task automatic t_opc();
    logic [15:0] d;
    @(posedge sys_clk);
    opsPending <= 1'b1;
    put(sesrq_pkg::SESRQ_CMD_OP_COMPLETE, 16'h0000);
    repeat (6) @(posedge sys_clk);
    ask(QRYL, d);
    check(d, 16'h0000);
    opsPending <= 1'b0;
    repeat (6) @(posedge sys_clk);
    ask(QRYL, d);
    check(d, 16'h0001);
  endtask : t_opc
  // mask 0x88 lets the two summaries request service, then only bits 2 and 4
  task automatic t_srq();
    @(posedge sys_clk);
    sb <= 4'b0001;
    settle(16'h0148);
    sb <= 4'b0010;
    settle(16'h01c0);
    put(SETS, 16'h0014);
    settle(16'h0080);
    sb <= 4'b1100;
    settle(16'h0154);
    sb <= 4'b0000;
  endtask : t_srq
  task automatic t_cls();
    logic [15:0] d;
    @(posedge sys_clk);
    src[4] <= 1'b1;
    @(posedge sys_clk);
    src[4] <= 1'b0;
    put(sesrq_pkg::SESRQ_CMD_CLEAR_STATUS, 16'h0000);
    repeat (2) @(posedge sys_clk);
    check(statusByte[5], 1'b0);
    ask(QRYL, d);
    check(d, 16'h0000);
  endtask : t_cls
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset_regs();
    t_events();
    t_opc();
    t_srq();
    t_cls();
    conclude();
  end
endmodule : sesrq_status_core_test
